/* File: rtl/ext_seq_defs.svh */
`ifndef EXT_SEQ_DEFS_SVH
`define EXT_SEQ_DEFS_SVH

// Address driven on every internal idle cycle
`define EXT_IDLE_ADDR 16'hffff
// Step from one address to the next one up
`define EXT_ADDR_STEP 16'h0001
// Step from the opcode to the second operand byte
`define EXT_ADDR_STEP2 16'h0002
// Length of the instruction in bytes, used for the return address
`define EXT_INSTR_BYTES 16'h0003
// Stack pointer drop after a subroutine call
`define EXT_SP_DROP 16'h0002
// Cycle numbers within an instruction
`define EXT_CYC_NONE 3'h0
`define EXT_CYC_1 3'h1
`define EXT_CYC_2 3'h2
`define EXT_CYC_3 3'h3
`define EXT_CYC_4 3'h4
`define EXT_CYC_5 3'h5
`define EXT_CYC_6 3'h6
// Operating mode in which internal reads are echoed on the bus
`define EXT_ECHO_MODE 3'h0
// Data bus value when nothing is placed on it
`define EXT_DATA_IDLE 8'h00

`endif

/* File: rtl/ext_seq_pkg.sv */
package ext_seq_pkg;

    // Instruction groups of the extended addressing mode
    typedef enum logic [3:0] {
        GRP_JUMP = 4'h0,
        GRP_ACC8 = 4'h1,
        GRP_STORE_ACC = 4'h2,
        GRP_LOAD16 = 4'h3,
        GRP_STORE16 = 4'h4,
        GRP_RMW = 4'h5,
        GRP_ZERO_TEST = 4'h6,
        GRP_ARITH16 = 4'h7,
        GRP_CALL = 4'h8
    } grp_t;

    // Source of the address bus in a cycle
    typedef enum logic [2:0] {
        ASEL_PC0 = 3'h0,
        ASEL_PC1 = 3'h1,
        ASEL_PC2 = 3'h2,
        ASEL_EA = 3'h3,
        ASEL_EA1 = 3'h4,
        ASEL_IDLE = 3'h5,
        ASEL_SP = 3'h6,
        ASEL_SPM1 = 3'h7
    } addr_sel_t;

    // Source of the data bus in a cycle
    typedef enum logic [2:0] {
        DSEL_NONE = 3'h0,
        DSEL_ACC = 3'h1,
        DSEL_HI16 = 3'h2,
        DSEL_LO16 = 3'h3,
        DSEL_NEWOP = 3'h4,
        DSEL_RETLO = 3'h5,
        DSEL_RETHI = 3'h6
    } data_sel_t;

endpackage

/* File: rtl/bus_cycle_table.sv */
`timescale 1ns/1ns
`include "ext_seq_defs.svh"

// Per-cycle bus plan for one instruction group
module bus_cycle_table import ext_seq_pkg::*; (
    input grp_t grp,
    input logic [2:0] cyc,
    output addr_sel_t addrSel,
    output data_sel_t dataSel,
    output logic writeCycle,
    output logic lastCycle
);

    // Number of cycles of each group
    function automatic logic [2:0] groupLength(input grp_t g);
        logic [2:0] n;
        n = `EXT_CYC_6;
        unique case (g)
            GRP_JUMP: n = `EXT_CYC_3;
            GRP_ACC8, GRP_STORE_ACC: n = `EXT_CYC_4;
            GRP_LOAD16, GRP_STORE16: n = `EXT_CYC_5;
            GRP_RMW, GRP_ZERO_TEST, GRP_ARITH16, GRP_CALL: n = `EXT_CYC_6;
            default: n = `EXT_CYC_6;
        endcase
        return n;
    endfunction

    // Address source by group and cycle
    function automatic addr_sel_t pickAddr(input grp_t g, input logic [2:0] c);
        addr_sel_t a;
        a = ASEL_IDLE;
        unique case (c)
            `EXT_CYC_1: a = ASEL_PC0;
            `EXT_CYC_2: a = ASEL_PC1;
            `EXT_CYC_3: a = ASEL_PC2;
            // Operand, destination or subroutine start
            `EXT_CYC_4: a = ASEL_EA;
            `EXT_CYC_5: begin
                if (g == GRP_RMW || g == GRP_ZERO_TEST) begin
                    a = ASEL_IDLE;
                end else if (g == GRP_CALL) begin
                    a = ASEL_SP;
                end else begin
                    a = ASEL_EA1;
                end
            end
            `EXT_CYC_6: begin
                if (g == GRP_RMW) begin
                    a = ASEL_EA;
                end else if (g == GRP_CALL) begin
                    a = ASEL_SPM1;
                end else begin
                    a = ASEL_IDLE;
                end
            end
            default: a = ASEL_IDLE;
        endcase
        return a;
    endfunction

    // Data source for write cycles
    function automatic data_sel_t pickData(input grp_t g, input logic [2:0] c);
        data_sel_t d;
        d = DSEL_NONE;
        if (g == GRP_STORE_ACC && c == `EXT_CYC_4) begin
            d = DSEL_ACC;
        end else if (g == GRP_STORE16 && c == `EXT_CYC_4) begin
            d = DSEL_HI16;
        end else if (g == GRP_STORE16 && c == `EXT_CYC_5) begin
            d = DSEL_LO16;
        end else if (g == GRP_RMW && c == `EXT_CYC_6) begin
            d = DSEL_NEWOP;
        end else if (g == GRP_CALL && c == `EXT_CYC_5) begin
            d = DSEL_RETLO;
        end else if (g == GRP_CALL && c == `EXT_CYC_6) begin
            d = DSEL_RETHI;
        end
        return d;
    endfunction

    assign addrSel = pickAddr(grp, cyc);
    assign dataSel = pickData(grp, cyc);
    // Zero test never writes, so it has no data source
    assign writeCycle = (dataSel != DSEL_NONE);
    assign lastCycle = (cyc == groupLength(grp));

endmodule

/* File: rtl/extended_mode_bus_sequencer.sv */
// What this block does
// - Jump: opcode, target high, target low
// - Accumulator ops: address bytes, then operand read
// - Accumulator store writes destination in cycle four
// - 16-bit loads read operand then operand plus one
// - 16-bit stores write high then low byte
// - Read-modify-write: read, idle, write back same address
// - Idle cycles drive all-ones address, read
// - Zero test replaces final write with idle
// - 16-bit compare/arith: two reads then idle
// - Call reads subroutine start in cycle four
// - Call pushes return low then high byte
// - Internal reads echo on bus only in mode zero
`timescale 1ns/1ns
`include "ext_seq_defs.svh"

module extended_mode_bus_sequencer import ext_seq_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic startValid,
    input wire grp_t instrGroup,
    input wire logic [15:0] opcodeAddr,
    input wire logic [15:0] stackPtr,
    input wire logic [7:0] accData,
    input wire logic [15:0] wideData,
    input wire logic [7:0] newOperand,
    input wire logic [7:0] dataIn,
    input wire logic internalRead,
    input wire logic [7:0] internalData,
    input wire logic [2:0] opMode,
    output logic [15:0] addrBus_r,
    output logic rwLine_r,
    output logic [7:0] dataOut_r,
    output logic dataOe_r,
    output logic busy_r,
    output logic done_r,
    output logic [15:0] targetAddr_r,
    output logic [15:0] spNew_r,
    output logic spLoad_r
);

    logic [2:0] cyc_r; // Cycle now on the bus, zero when idle
    grp_t grp_r; // Group now running
    logic [15:0] pc_r; // Opcode address
    logic [15:0] sp_r; // Stack pointer at start
    logic [7:0] hi_r; // High address byte fetched in cycle two
    logic [15:0] ea_r; // Full extended address
    logic last_r; // Current cycle is the group's last

    logic free; // No instruction or its last cycle
    logic startNow; // A new instruction starts next cycle
    logic [2:0] cyc_nxt; // Next cycle number
    grp_t grp_nxt; // Group of next cycle
    logic [15:0] pcNow; // Opcode address for next cycle
    logic [15:0] spNow; // Stack pointer for next cycle
    logic [15:0] eaNow; // Extended address for next cycle
    logic [15:0] retAddr; // Address after the instruction
    addr_sel_t addrSel; // Address source of next cycle
    data_sel_t dataSel; // Data source of next cycle
    logic writeNxt; // Next cycle writes
    logic lastNxt; // Next cycle is last
    logic echoNxt; // Next cycle echoes an internal read
    logic [15:0] addr_nxt; // Next address bus
    logic [7:0] data_nxt; // Next data bus

    // Sequencing of cycles, back to back starts allowed
    assign free = (cyc_r == `EXT_CYC_NONE) || last_r;
    assign startNow = startValid && free;
    assign cyc_nxt = startNow ? `EXT_CYC_1 : (free ? `EXT_CYC_NONE : cyc_r + `EXT_CYC_1);
    assign grp_nxt = startNow ? instrGroup : grp_r;
    assign pcNow = startNow ? opcodeAddr : pc_r;
    assign spNow = startNow ? stackPtr : sp_r;
    // Low address byte arrives at the end of cycle three
    assign eaNow = (cyc_r == `EXT_CYC_3) ? {hi_r, dataIn} : ea_r;
    assign retAddr = pc_r + `EXT_INSTR_BYTES;

    bus_cycle_table bus_cycle_table_i (
        .grp(grp_nxt),
        .cyc(cyc_nxt),
        .addrSel(addrSel),
        .dataSel(dataSel),
        .writeCycle(writeNxt),
        .lastCycle(lastNxt)
    );

    // Idle cycles drive the all-ones address
    assign addr_nxt = (cyc_nxt == `EXT_CYC_NONE) ? `EXT_IDLE_ADDR :
                      (addrSel == ASEL_PC0) ? pcNow :
                      (addrSel == ASEL_PC1) ? pcNow + `EXT_ADDR_STEP :
                      (addrSel == ASEL_PC2) ? pcNow + `EXT_ADDR_STEP2 :
                      (addrSel == ASEL_EA) ? eaNow :
                      (addrSel == ASEL_EA1) ? eaNow + `EXT_ADDR_STEP :
                      (addrSel == ASEL_SP) ? spNow :
                      (addrSel == ASEL_SPM1) ? spNow - `EXT_ADDR_STEP : `EXT_IDLE_ADDR;

    // Echo internal reads only in mode zero
    // Idle cycles carry the restart vector from memory, so they never echo
    assign echoNxt = !writeNxt && internalRead && (opMode == `EXT_ECHO_MODE) &&
                     (cyc_nxt != `EXT_CYC_NONE) && (addrSel != ASEL_IDLE);

    assign data_nxt = (dataSel == DSEL_ACC) ? accData :
                      (dataSel == DSEL_HI16) ? wideData[15:8] :
                      (dataSel == DSEL_LO16) ? wideData[7:0] :
                      (dataSel == DSEL_NEWOP) ? newOperand :
                      (dataSel == DSEL_RETLO) ? retAddr[7:0] :
                      (dataSel == DSEL_RETHI) ? retAddr[15:8] :
                      echoNxt ? internalData : `EXT_DATA_IDLE;

    // Sequence state
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_r <= `EXT_CYC_NONE;
            grp_r <= GRP_JUMP;
            pc_r <= `EXT_IDLE_ADDR;
            sp_r <= `EXT_IDLE_ADDR;
            last_r <= 1'b0;
        end else begin
            cyc_r <= cyc_nxt;
            grp_r <= grp_nxt;
            pc_r <= pcNow;
            sp_r <= spNow;
            last_r <= lastNxt && (cyc_nxt != `EXT_CYC_NONE);
        end
    end

    // Capture of the extended address bytes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_r <= `EXT_DATA_IDLE;
            ea_r <= `EXT_IDLE_ADDR;
        end else begin
            hi_r <= (cyc_r == `EXT_CYC_2) ? dataIn : hi_r;
            ea_r <= eaNow;
        end
    end

    // Bus outputs, read/write low only on write cycles
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addrBus_r <= `EXT_IDLE_ADDR;
            rwLine_r <= 1'b1;
            dataOut_r <= `EXT_DATA_IDLE;
            dataOe_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            addrBus_r <= addr_nxt;
            rwLine_r <= !writeNxt;
            dataOut_r <= data_nxt;
            dataOe_r <= writeNxt || echoNxt;
            busy_r <= (cyc_nxt != `EXT_CYC_NONE);
        end
    end

    // Completion results for the core
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_r <= 1'b0;
            targetAddr_r <= `EXT_IDLE_ADDR;
            spNew_r <= `EXT_IDLE_ADDR;
            spLoad_r <= 1'b0;
        end else begin
            done_r <= (cyc_r != `EXT_CYC_NONE) && last_r;
            targetAddr_r <= ((cyc_r != `EXT_CYC_NONE) && last_r) ? eaNow : targetAddr_r;
            // Stack pointer drops by two after a call
            spNew_r <= sp_r - `EXT_SP_DROP;
            spLoad_r <= (cyc_r != `EXT_CYC_NONE) && last_r && (grp_r == GRP_CALL);
        end
    end

    // Helper views of the cycle on the bus
    sequence callPushSeq;
        !rwLine_r && dataOut_r == retAddr[7:0] ##1 !rwLine_r && dataOut_r == retAddr[15:8];
    endsequence

    jump_length_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cyc_r == `EXT_CYC_1 && grp_r == GRP_JUMP) |-> rwLine_r [*3] ##1 (!busy_r || cyc_r == `EXT_CYC_1))
        else $error("jump does not end after three reads");
    acc_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cyc_r == `EXT_CYC_4 && grp_r == GRP_STORE_ACC) |-> !rwLine_r && dataOe_r && addrBus_r == ea_r)
        else $error("accumulator store not written at destination");
    load_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cyc_r == `EXT_CYC_5 && grp_r == GRP_LOAD16) |->
            rwLine_r && addrBus_r == $past(addrBus_r) + `EXT_ADDR_STEP)
        else $error("second load byte not at next address");
    store_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cyc_r == `EXT_CYC_4 && grp_r == GRP_STORE16) |->
            !rwLine_r ##1 !rwLine_r && addrBus_r == $past(addrBus_r) + `EXT_ADDR_STEP)
        else $error("16-bit store bytes misplaced");
    rmw_back_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cyc_r == `EXT_CYC_4 && grp_r == GRP_RMW) |-> rwLine_r ##1 addrBus_r == `EXT_IDLE_ADDR
            ##1 !rwLine_r && addrBus_r == $past(addrBus_r, 2))
        else $error("read-modify-write sequence wrong");
    idle_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cyc_r == `EXT_CYC_6 && grp_r == GRP_ARITH16) |-> addrBus_r == `EXT_IDLE_ADDR && rwLine_r && !dataOe_r)
        else $error("idle cycle not all-ones read");
    rmw_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cyc_r == `EXT_CYC_5 && grp_r == GRP_RMW) |-> addrBus_r == `EXT_IDLE_ADDR && rwLine_r && !dataOe_r)
        else $error("read-modify-write idle cycle drives the bus");
    zero_test_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cyc_r == `EXT_CYC_5 && grp_r == GRP_ZERO_TEST) |-> (addrBus_r == `EXT_IDLE_ADDR && rwLine_r) [*2])
        else $error("zero test performed a write");
    call_push_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cyc_r == `EXT_CYC_5 && grp_r == GRP_CALL) |-> addrBus_r == sp_r ##0 callPushSeq)
        else $error("call return address push wrong");
    sp_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cyc_r == `EXT_CYC_6 && grp_r == GRP_CALL) |=> spLoad_r && spNew_r == $past(sp_r) - `EXT_SP_DROP)
        else $error("stack pointer not dropped by two");
    echo_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (dataOe_r && rwLine_r) |-> $past(opMode) == `EXT_ECHO_MODE)
        else $error("internal read echoed outside mode zero");

endmodule

/* File: sim/ext_mem_model.sv */
`timescale 1ns/1ns

// Behavioural memory and peripherals on the far side of the processor bus
module ext_mem_model (
    input wire logic sys_clk,
    input wire logic [15:0] addrBus,
    input wire logic rwLine,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    output logic [7:0] dataIn
);
    // Locations written so far; all others hold an address pattern
    logic [7:0] mem [logic [15:0]];
    // Last byte read, inverted while nobody drives the bus
    logic [7:0] lastRead = 8'h00;

    // Byte held at an address
    function automatic logic [7:0] peek(logic [15:0] a);
        if (mem.exists(a)) begin
            return mem[a];
        end
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    // Read cycles return the stored byte; a write leaves the line floating
    assign dataIn = rwLine ? peek(addrBus) : ~lastRead;

    // Commit writes mid-cycle, well clear of the edges that move the bus
    always @(negedge sys_clk) begin
        if (!rwLine && dataOe) begin
            mem[addrBus] = dataOut;
        end
    end

    // Remember the last byte returned
    always @(posedge sys_clk) begin
        if (rwLine) begin
            lastRead <= dataIn;
        end
    end
endmodule

/* File: sim/extended_mode_bus_sequencer_tb_top.sv */
`timescale 1ns/1ns

module extended_mode_bus_sequencer_tb_top import ext_seq_pkg::*; ();
    // Stimulus and observed ports
    logic sys_clk = 1'b0, rst_n = 1'b0, startValid = 1'b0, internalRead = 1'b0;
    grp_t instrGroup = GRP_JUMP;
    logic [15:0] opcodeAddr = 16'h0000, stackPtr = 16'h0000, wideData = 16'h0000;
    logic [7:0] accData = 8'h00, newOperand = 8'h00, internalData = 8'h00, dataIn, dataOut_r;
    logic [2:0] opMode = 3'h0;
    logic [15:0] addrBus_r, targetAddr_r, spNew_r;
    logic rwLine_r, dataOe_r, busy_r, done_r, spLoad_r;
    int err_count = 0, comparisons = 0;
    // Next request, and the instruction that finished last
    grp_t nGrp, lastG;
    logic [15:0] nPc, nSp, nWide, lastSp, lastEa;
    logic [7:0] nAcc, nNew;
    logic [2:0] nMode;

    extended_mode_bus_sequencer extended_mode_bus_sequencer_i (.sys_clk, .rst_n, .startValid,
        .instrGroup, .opcodeAddr, .stackPtr, .accData, .wideData, .newOperand, .dataIn,
        .internalRead, .internalData, .opMode, .addrBus_r, .rwLine_r, .dataOut_r, .dataOe_r,
        .busy_r, .done_r, .targetAddr_r, .spNew_r, .spLoad_r);
    ext_mem_model ext_mem_model_i (.sys_clk, .addrBus(addrBus_r), .rwLine(rwLine_r),
        .dataOut(dataOut_r), .dataOe(dataOe_r), .dataIn);

    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;

    // Compare one value and count it
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic close_out();
        if (err_count == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Cycles per group
    function automatic int cyc_count(grp_t g);
        case (g)
            GRP_JUMP: return 3;
            GRP_ACC8, GRP_STORE_ACC: return 4;
            GRP_LOAD16, GRP_STORE16: return 5;
            default: return 6;
        endcase
    endfunction

    // Expected {address, read/write, data} of cycle k
    function automatic logic [24:0] exp_cyc(grp_t g, int k, logic [15:0] pc, logic [15:0] sp,
        logic [15:0] ea, logic [15:0] wd, logic [7:0] acc, logic [7:0] nw);
        logic [15:0] ra;
        ra = pc + 16'h0003;
        if (k <= 3) begin
            return {pc + 16'(k - 1), 1'b1, 8'h00};
        end
        case (g)
            GRP_STORE_ACC: return {ea, 1'b0, acc};
            GRP_LOAD16: return {(k == 4) ? ea : ea + 16'h0001, 1'b1, 8'h00};
            GRP_STORE16: return (k == 4) ? {ea, 1'b0, wd[15:8]} : {ea + 16'h0001, 1'b0, wd[7:0]};
            GRP_RMW: return (k == 4) ? {ea, 1'b1, 8'h00} : (k == 5) ? {16'hffff, 1'b1, 8'h00} : {ea, 1'b0, nw};
            GRP_ZERO_TEST: return (k == 4) ? {ea, 1'b1, 8'h00} : {16'hffff, 1'b1, 8'h00};
            GRP_ARITH16: return (k == 6) ? {16'hffff, 1'b1, 8'h00} : {ea + 16'(k - 4), 1'b1, 8'h00};
            GRP_CALL: return (k == 4) ? {ea, 1'b1, 8'h00} : (k == 5) ? {sp, 1'b0, ra[7:0]} :
                {sp - 16'h0001, 1'b0, ra[15:8]};
            default: return {ea, 1'b1, 8'h00};
        endcase
    endfunction

    // Draw the next request; the first nine cover every group, some at address edges
    task automatic pick(int i);
        nGrp = (i < 9) ? grp_t'(i) : grp_t'($urandom_range(8, 0));
        nPc = (i == 8 || i == 5) ? 16'hfffd : 16'($urandom);
        nSp = (i == 8) ? 16'h0000 : 16'($urandom);
        nWide = 16'($urandom);
        nAcc = 8'($urandom);
        nNew = 8'($urandom);
        nMode = 3'($urandom_range(2, 0));
    endtask

    // Place the drawn request on the inputs
    task automatic drive_req();
        startValid = 1'b1;
        instrGroup = nGrp;
        opcodeAddr = nPc;
        stackPtr = nSp;
        wideData = nWide;
        accData = nAcc;
        newOperand = nNew;
        opMode = nMode;
    endtask

    // Completion results of the previous instruction
    task automatic check_done();
        check("done", 16'(done_r), 16'h0001); // Completion pulse
        check("target", targetAddr_r, lastEa); // Extended address taken
        check("spLoad", 16'(spLoad_r), 16'(lastG == GRP_CALL)); // Stack update
        if (lastG == GRP_CALL) begin
            check("spNew", spNew_r, lastSp - 16'h0002); // Stack drops by two
        end
    endtask

    // Follow one instruction cycle by cycle
    task automatic run_instr(logic b2b, logic prevB2b, logic glitch);
        grp_t g;
        logic [15:0] pc, sp, wd, ea;
        logic [7:0] acc, nw;
        logic [24:0] e;
        int n;
        g = instrGroup;
        pc = opcodeAddr;
        sp = stackPtr;
        wd = wideData;
        acc = accData;
        nw = newOperand;
        n = cyc_count(g);
        for (int k = 1; k <= n; k++) begin
            @(posedge sys_clk);
            #1;
            if (k == 1) begin
                startValid = 1'b0;
                ea = {ext_mem_model_i.peek(pc + 16'h0001), ext_mem_model_i.peek(pc + 16'h0002)};
                if (prevB2b) begin
                    check_done();
                end
            end
            e = exp_cyc(g, k, pc, sp, ea, wd, acc, nw);
            check("addr", addrBus_r, e[24:9]); // Bus address plan
            check("rw", 16'(rwLine_r), 16'(e[8])); // Read or write
            check("busy", 16'(busy_r), 16'h0001); // Instruction in progress
            if (!e[8]) begin
                check("wrOe", 16'(dataOe_r), 16'h0001); // Drives data on writes
                check("wrData", 16'(dataOut_r), 16'(e[7:0])); // Written byte
            end else if (e[24:9] != 16'hffff) begin
                check("echoOe", 16'(dataOe_r), 16'(internalRead && opMode == 3'h0)); // Echo only in mode zero
                if (internalRead && opMode == 3'h0) begin
                    check("echoData", 16'(dataOut_r), 16'(internalData)); // Echoed value
                end
            end
            // Internal reads only outside the address fetch
            internalRead = (k <= 2 || (k == n && !b2b)) ? 1'b0 : 1'($urandom);
            internalData = 8'($urandom);
            // Requests while busy must be ignored
            if (glitch && n > 3 && k == 2) begin
                startValid = 1'b1;
                opcodeAddr = ~pc;
            end
            if (glitch && n > 3 && k == 3) begin
                startValid = 1'b0;
            end
            if (k == n && b2b) begin
                drive_req();
            end
        end
        lastG = g;
        lastSp = sp;
        lastEa = ea;
    endtask

    // Cut a hang short
    initial begin
        #400000;
        err_count++;
        close_out();
    end

    // Main sequence
    initial begin
        logic b2b, prevB2b;
        int seed;
        seed = $urandom(32'h7aded506);
        prevB2b = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        check("rstAddr", addrBus_r, 16'hffff); // Idle address in reset
        check("rstTarget", targetAddr_r, 16'hffff); // Reset value
        check("rstBusy", 16'(busy_r), 16'h0000); // Reset value
        rst_n = 1'b1;
        pick(0);
        drive_req();
        for (int i = 0; i < 80; i++) begin
            b2b = (i < 79) && (i == 1 || i == 3 || $urandom_range(1, 0) == 1);
            if (b2b) begin
                pick(i + 1);
            end
            run_instr(b2b, prevB2b, $urandom_range(3, 0) == 0);
            if (!b2b) begin
                @(posedge sys_clk);
                #1;
                check_done();
                check("idleAddr", addrBus_r, 16'hffff); // Idle bus between instructions
                check("idleRw", 16'(rwLine_r), 16'h0001); // Idle bus reads
                check("idleOe", 16'(dataOe_r), 16'h0000); // Bus released when idle
                @(posedge sys_clk);
                #1;
                check("donePulse", 16'(done_r), 16'h0000); // Pulse lasts one cycle
                check("spPulse", 16'(spLoad_r), 16'h0000); // Pulse lasts one cycle
                pick(i + 1);
                drive_req();
            end
            prevB2b = b2b;
        end
        close_out();
    end
endmodule
